// ===== verilog/rcd_params.svh
// Offsets, field positions and reset values of the regulator control block
`ifndef RCD_PARAMS_SVH
`define RCD_PARAMS_SVH
`define RCD_CTRL_ADDR      8'hC9
`define RCD_CTRL_PAGE      8'h00
`define RCD_IRQ_EN_ADDR    8'hE7
`define RCD_IRQ_PRI_ADDR   8'hF7
`define RCD_BIT_OFF        7
`define RCD_BIT_RSVD       6
`define RCD_BIT_LEVEL      4
`define RCD_BIT_DROPOUT    0
`define RCD_BIT_IRQ        0
`define RCD_CTRL_RESET     8'h50
`define RCD_IRQ_REG_RESET  8'h00
`endif

// ===== verilog/rcd_pkg.sv
// Types shared by the regulator control block
package rcd_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] page;
      logic [7:0] wdata;
   } rcd_sfr_req_s;
   typedef enum logic [1:0] {
      RCD_SEL_NONE = 2'b00,
      RCD_SEL_CTRL = 2'b01,
      RCD_SEL_IRQ_EN  = 2'b10,
      RCD_SEL_IRQ_PRI = 2'b11
   } rcd_sel_e;
endpackage

// ===== verilog/rcd_regulator_control.sv
// Regulator control register, dropout status and dropout interrupt request
// Function
// - Regulator enabled after every reset
// - Bit 7 read/write regulator off, resets zero
// - Bit 4 output level select, resets one
// - Bit 6 reserved, always reads one
// - Bit 5 reads zero, writes ignored
// - Bits 3..1 read zero, writes ignored
// - Bit 0 read-only live dropout indicator
// - Hardware clears dropout when condition ends
// - Enabled dropout raises interrupt request
// - No pending flag for dropout interrupt
// - Priority bit 0 of second priority register
// - Control register at 0xC9, page 0x00
`timescale 1ns/1ns
`include "rcd_params.svh"
module rcd_regulator_control
   import rcd_pkg::*;
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire rcd_sfr_req_s i_sfr,
   input  wire logic         i_dropout,
   output logic [7:0]        o_rdata,
   output logic              o_regulator_off,
   output logic              o_output_level_select,
   output logic              o_dropout_irq,
   output logic              o_dropout_irq_priority
);
   logic       regulator_off_q;
   logic       level_q;
   logic       dropout_q;
   logic       irq_en_q;
   logic       irq_pri_q;
   logic [7:0] rdata_q;
   logic       irq_q;
   rcd_sel_e   sel;
   wire        hit_ctrl = (i_sfr.addr == `RCD_CTRL_ADDR) &&
                          (i_sfr.page == `RCD_CTRL_PAGE);
   wire        hit_irq_en = (i_sfr.addr == `RCD_IRQ_EN_ADDR);
   wire        hit_irq_pri = (i_sfr.addr == `RCD_IRQ_PRI_ADDR);
   always_comb begin
      if (hit_ctrl) begin
         sel = RCD_SEL_CTRL;
      end else if (hit_irq_en) begin
         sel = RCD_SEL_IRQ_EN;
      end else if (hit_irq_pri) begin
         sel = RCD_SEL_IRQ_PRI;
      end else begin
         sel = RCD_SEL_NONE;
      end
   end
   wire wr_ctrl = i_sfr.wr && (sel == RCD_SEL_CTRL);
   wire wr_irq_en = i_sfr.wr && (sel == RCD_SEL_IRQ_EN);
   wire wr_irq_pri = i_sfr.wr && (sel == RCD_SEL_IRQ_PRI);
   // Bit 6 is a constant one, bits 5 and 3..1 constant zero
   wire [7:0] ctrl_view = {regulator_off_q, 1'b1, 1'b0, level_q,
                           3'b000, dropout_q};
   wire [7:0] rdata_d = (sel == RCD_SEL_CTRL) ? ctrl_view :
                        (sel == RCD_SEL_IRQ_EN) ? {7'h00, irq_en_q} :
                        (sel == RCD_SEL_IRQ_PRI) ? {7'h00, irq_pri_q} : 8'h00;
   // No pending flag: the request follows status and enable directly
   wire irq_d = dropout_q & irq_en_q;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         regulator_off_q <= 1'b0;
         level_q         <= 1'b1;
      end else if (wr_ctrl) begin
         regulator_off_q <= i_sfr.wdata[`RCD_BIT_OFF];
         level_q         <= i_sfr.wdata[`RCD_BIT_LEVEL];
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_en_q  <= 1'b0;
         irq_pri_q <= 1'b0;
      end else begin
         if (wr_irq_en) begin
            irq_en_q <= i_sfr.wdata[`RCD_BIT_IRQ];
         end
         if (wr_irq_pri) begin
            irq_pri_q <= i_sfr.wdata[`RCD_BIT_IRQ];
         end
      end
   end
   // Live status; writes cannot touch it, it follows the analog flag
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         dropout_q <= 1'b0;
         irq_q     <= 1'b0;
         rdata_q   <= 8'h00;
      end else begin
         dropout_q <= i_dropout;
         irq_q     <= irq_d;
         rdata_q   <= rdata_d;
      end
   end
   assign o_rdata                = rdata_q;
   assign o_regulator_off        = regulator_off_q;
   assign o_output_level_select  = level_q;
   assign o_dropout_irq          = irq_q;
   assign o_dropout_irq_priority = irq_pri_q;

   // Read data lags one cycle, so the status bit is compared with its old value
   a_ctrl_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sfr.rd && sel == RCD_SEL_CTRL)
      |=> (o_rdata[6:5] == 2'b10 && o_rdata[3:1] == 3'b000 && o_rdata[0] == $past(dropout_q)))
      else $error("control readback fixed bits wrong");

   a_off_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_ctrl
      |=> o_regulator_off == $past(i_sfr.wdata[`RCD_BIT_OFF]))
      else $error("regulator off not written");

   a_level_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_ctrl
      |=> o_output_level_select == $past(i_sfr.wdata[`RCD_BIT_LEVEL]))
      else $error("level select not written");

   a_off_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !wr_ctrl
      |=> $stable(o_regulator_off))
      else $error("regulator off changed without write");

   a_level_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !wr_ctrl
      |=> $stable(o_output_level_select))
      else $error("level select changed without write");

   a_dropout_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_dropout ##1 1'b1
      |=> !o_dropout_irq)
      else $error("request left after dropout ended");

   sequence s_drop_enabled;
      i_dropout && irq_en_q ##1 i_dropout && irq_en_q;
   endsequence

   a_irq_raise: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_drop_enabled
      |=> o_dropout_irq)
      else $error("dropout request missing");

   a_irq_level: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_dropout_irq
      |-> $past(dropout_q) && $past(irq_en_q))
      else $error("request without cause");

   a_no_pending: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !irq_en_q
      |=> !o_dropout_irq)
      else $error("request held after enable cleared");

   a_prio_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_irq_pri
      |=> o_dropout_irq_priority == $past(i_sfr.wdata[`RCD_BIT_IRQ]))
      else $error("priority not written");

   a_decode_page: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sfr.wr && i_sfr.page != `RCD_CTRL_PAGE && !hit_irq_en && !hit_irq_pri)
      |=> $stable(o_output_level_select))
      else $error("write on wrong page taken");

   // Reset values are checked on the edge after reset, so no disable here
   a_off_at_reset: assert property (@(posedge i_sys_clk)
      $past(i_rst)
      |-> !o_regulator_off)
      else $error("regulator off after reset");

   a_level_at_reset: assert property (@(posedge i_sys_clk)
      $past(i_rst)
      |-> o_output_level_select)
      else $error("level select not one after reset");

   a_irq_at_reset: assert property (@(posedge i_sys_clk)
      $past(i_rst)
      |-> !o_dropout_irq)
      else $error("request high after reset");

   a_prio_at_reset: assert property (@(posedge i_sys_clk)
      $past(i_rst)
      |-> !o_dropout_irq_priority)
      else $error("priority set after reset");

   a_rsvd_one: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_CTRL
      |=> o_rdata[`RCD_BIT_RSVD])
      else $error("reserved bit not one");

   a_bit5_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_CTRL
      |=> !o_rdata[5])
      else $error("unused bit five not zero");

   a_bits31_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_CTRL
      |=> o_rdata[3:1] == 3'b000)
      else $error("unused low bits not zero");

   a_off_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_CTRL
      |=> o_rdata[`RCD_BIT_OFF] == $past(o_regulator_off))
      else $error("regulator off reads back wrong");

   a_level_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_CTRL
      |=> o_rdata[`RCD_BIT_LEVEL] == $past(o_output_level_select))
      else $error("level select reads back wrong");

   a_dropout_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_CTRL
      |=> o_rdata[`RCD_BIT_DROPOUT] == $past(dropout_q))
      else $error("dropout status reads back wrong");

   a_dropout_track: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      1'b1
      |=> dropout_q == $past(i_dropout))
      else $error("dropout status does not follow the regulator");

   a_dropout_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_dropout
      |=> !dropout_q)
      else $error("dropout status not cleared by hardware");

   a_en_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_irq_en
      |=> irq_en_q == $past(i_sfr.wdata[`RCD_BIT_IRQ]))
      else $error("dropout enable not written");

   a_en_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !wr_irq_en
      |=> $stable(irq_en_q))
      else $error("dropout enable changed without write");

   a_prio_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !wr_irq_pri
      |=> $stable(o_dropout_irq_priority))
      else $error("priority changed without write");

   a_en_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_IRQ_EN
      |=> o_rdata == {7'h00, $past(irq_en_q)})
      else $error("dropout enable reads back wrong");

   a_prio_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_IRQ_PRI
      |=> o_rdata == {7'h00, $past(o_dropout_irq_priority)})
      else $error("priority reads back wrong");

   a_unmapped_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sel == RCD_SEL_NONE
      |=> o_rdata == 8'h00)
      else $error("unmapped address reads nonzero");

   a_wrong_page_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sfr.addr == `RCD_CTRL_ADDR && i_sfr.page != `RCD_CTRL_PAGE)
      |=> o_rdata == 8'h00)
      else $error("control visible on wrong page");

   a_wrong_page_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sfr.wr && i_sfr.addr == `RCD_CTRL_ADDR && i_sfr.page != `RCD_CTRL_PAGE)
      |=> $stable(o_regulator_off))
      else $error("regulator off written on wrong page");

   a_irq_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (dropout_q && irq_en_q)
      |=> o_dropout_irq)
      else $error("request not held while dropout persists");

   a_irq_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!dropout_q || !irq_en_q)
      |=> !o_dropout_irq)
      else $error("request stored beyond its cause");

   sequence s_enable_cleared;
      wr_irq_en && !i_sfr.wdata[`RCD_BIT_IRQ];
   endsequence

   a_irq_drop_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_enable_cleared
      |=> ##1 !o_dropout_irq)
      else $error("request left after enable cleared");

   sequence s_drop_gone;
      !i_dropout ##1 !i_dropout;
   endsequence

   a_irq_gone: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_drop_gone
      |=> !o_dropout_irq)
      else $error("request left after dropout gone");

   a_off_read_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sfr.rd && !i_sfr.wr)
      |=> $stable(o_regulator_off))
      else $error("read changed regulator off");

   a_level_read_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sfr.rd && !i_sfr.wr)
      |=> $stable(o_output_level_select))
      else $error("read changed level select");

   a_pri_leaves_en: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_irq_pri
      |=> $stable(irq_en_q))
      else $error("priority write changed enable");

   a_en_leaves_pri: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_irq_en
      |=> $stable(o_dropout_irq_priority))
      else $error("enable write changed priority");

   a_ctrl_leaves_en: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_ctrl
      |=> $stable(irq_en_q))
      else $error("control write changed enable");

endmodule

// ===== test/tb_regulator_control_dropout.sv
// Register-level bench for the regulator control and dropout request
`timescale 1ns/1ns
`include "rcd_params.svh"
module tb_regulator_control_dropout
   import rcd_pkg::*;
;
   logic         i_sys_clk = 1'b0;
   logic         i_rst = 1'b1;
   rcd_sfr_req_s i_sfr = '0;
   logic         i_dropout = 1'b0;
   logic [7:0]   o_rdata;
   logic         o_regulator_off, o_output_level_select, o_dropout_irq, o_dropout_irq_priority;
   int           fail_count = 0;
   int           checks_done = 0;
   int           cycles = 0;

   rcd_regulator_control i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sfr(i_sfr),
      .i_dropout(i_dropout), .o_rdata(o_rdata), .o_regulator_off(o_regulator_off),
      .o_output_level_select(o_output_level_select), .o_dropout_irq(o_dropout_irq),
      .o_dropout_irq_priority(o_dropout_irq_priority));

   always #2 i_sys_clk = ~i_sys_clk;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Ceiling well above the roughly 45 cycles the tests need
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
      @(posedge i_sys_clk) #1;
      i_sfr = '{wr: 1'b1, rd: 1'b0, addr: a, page: p, wdata: d};
      @(posedge i_sys_clk) #1;
      i_sfr.wr = 1'b0;
   endtask

   // Read data is registered, so it is taken one edge after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk) #1;
      i_sfr = '{wr: 1'b0, rd: 1'b1, addr: a, page: 8'h00, wdata: 8'h00};
      @(posedge i_sys_clk) #1;
      chk(o_rdata, exp);
      i_sfr.rd = 1'b0;
   endtask

   initial begin
      repeat (6) @(posedge i_sys_clk);
      #1 i_rst = 1'b0;
      chk(o_regulator_off, 8'h00);
      chk(o_output_level_select, 8'h01);
      rdchk(`RCD_CTRL_ADDR, 8'h50);
      $display("test reset values done");
      wr(`RCD_CTRL_ADDR, 8'h00, 8'hFF);
      rdchk(`RCD_CTRL_ADDR, 8'hD0);
      chk(o_regulator_off, 8'h01);
      wr(`RCD_CTRL_ADDR, 8'h00, 8'h40);
      rdchk(`RCD_CTRL_ADDR, 8'h40);
      chk(o_output_level_select, 8'h00);
      wr(`RCD_CTRL_ADDR, 8'h01, 8'hD0);
      rdchk(`RCD_CTRL_ADDR, 8'h40);
      rdchk(8'hC8, 8'h00);
      $display("test register access done");
      i_dropout = 1'b1;
      repeat (2) @(posedge i_sys_clk);
      #1 chk(o_dropout_irq, 8'h00);
      rdchk(`RCD_CTRL_ADDR, 8'h41);
      wr(`RCD_IRQ_EN_ADDR, 8'h00, 8'h01);
      @(posedge i_sys_clk) #1;
      chk(o_dropout_irq, 8'h01);
      wr(`RCD_IRQ_PRI_ADDR, 8'h00, 8'h01);
      chk(o_dropout_irq_priority, 8'h01);
      rdchk(`RCD_IRQ_PRI_ADDR, 8'h01);
      i_dropout = 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1 chk(o_dropout_irq, 8'h00);
      rdchk(`RCD_CTRL_ADDR, 8'h40);
      $display("test dropout request done");
      wr(`RCD_CTRL_ADDR, 8'h00, 8'hC0);
      chk(o_regulator_off, 8'h01);
      @(posedge i_sys_clk) #1 i_rst = 1'b1;
      @(posedge i_sys_clk) #1 i_rst = 1'b0;
      chk(o_regulator_off, 8'h00);
      chk(o_output_level_select, 8'h01);
      chk(o_dropout_irq_priority, 8'h00);
      rdchk(`RCD_IRQ_EN_ADDR, 8'h00);
      rdchk(`RCD_CTRL_ADDR, 8'h50);
      $display("test mid-run reset done");
      complete_run();
   end
endmodule
